//--- alae_pkg.sv
// Package with types and constants for the axis limit and amplifier enable block
package alae_pkg;
    localparam int CMD_W       = 16;              // Signed motor command width
    localparam int RATE_W      = 16;              // Deceleration rate width
    localparam logic [7:0] ERR_NONE  = 8'h00;
    localparam logic [7:0] ERR_LIMIT = 8'h16;     // Code 22: begin refused by limit
    localparam logic [15:0] CMD_FULL_POS = 16'h7FFF; // +10 V full scale
    localparam logic [15:0] CMD_FULL_NEG = 16'h8001; // -10 V full scale
    localparam logic [15:0] ZERO_CMD = 16'h0000;
    localparam logic [15:0] PEAK_CYCLES = 16'h0400; // Cycles peak level may stand
    localparam logic MT_SERVO = 1'b0;
    localparam logic MT_STEP  = 1'b1;

    // Axis motion states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_MOVE  = 2'b01,
        ST_DECEL = 2'b10,
        ST_OFF   = 2'b11
    } alae_state_t;

    // Configuration group
    typedef struct packed {
        logic              motorType;
        logic              offOnError;
        logic              handlerPresent;
        logic [CMD_W-1:0]  continuousLimit;
        logic [CMD_W-1:0]  peakLimit;
        logic [RATE_W-1:0] limitDecelRate;
    } alae_cfg_t;

    // Status group
    typedef struct packed {
        logic       forwardLimitFlag;
        logic       reverseLimitFlag;
        logic       moving;
        logic       servoOn;
        logic [7:0] errorCode;
    } alae_status_t;
endpackage

//--- alae_sync.sv
// Two-flop synchroniser for one limit input
`timescale 1ns/1ps
module alae_sync (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic din,
    output logic      dout
);
    logic stage;

    // Double register; stage feeds only dout
    always_ff @(posedge clock) begin
        if (!rstn) begin
            stage <= 1'b0;
            dout  <= 1'b0;
        end else begin
            stage <= din;
            dout  <= stage;
        end
    end
endmodule

//--- alae_axis.sv
// Per-axis limit supervision, amplifier enable and command output logic
`timescale 1ns/1ps
// Functional notes
// RULE_01: Active forward limit blocks forward motion at once.
// RULE_02: Active reverse limit blocks reverse motion at once.
// RULE_03: Limit hit while moving makes decelerated stop at limit rate; in step mode stepOut instead stops at once.
// RULE_04: By default axis stays servo-on holding position after limit stop.
// RULE_05: With off-on-error set, a limit activation disables the axis.
// RULE_06: Limit activation traps thread zero to handler if present.
// RULE_07: New motion toward a limit refused until that limit releases.
// RULE_08: Begin refused by a limit records error code 22.
// RULE_09: Forward and reverse limit flags follow the limit input levels.
// RULE_10: Amplifier enable is active high while amplifier expected on.
// RULE_11: Motor-off deasserts amplifier enable, servo-here asserts it.
// RULE_12: Motor type selects analog command or step and direction.
// RULE_13: Servo command clamped to continuous limit.
// RULE_14: Servo command clamped to separate peak limit.
// RULE_15: Analog command spans plus and minus ten volts full scale.
// RULE_16: Sine commutation drives a second command output for one motor.
// RULE_17: Limit inputs synchronised before edges are evaluated.
module alae_axis
    import alae_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   rstn,
    input  wire logic                   forwardLimitInput,
    input  wire logic                   reverseLimitInput,
    input  wire alae_pkg::alae_cfg_t    cfg,
    input  wire logic                   beginMotion,
    input  wire logic                   beginDirReverse,
    input  wire logic                   motorOffCommand,
    input  wire logic                   servoHereCommand,
    input  wire logic                   sineCommutation,
    input  wire logic                   errorClear,
    input  wire logic [15:0]            demandCommand,
    input  wire logic [15:0]            demandPhaseB,
    input  wire logic                   stepPulseIn,
    output alae_pkg::alae_status_t      status,
    output logic                        ampEnable,
    output logic [15:0]                 motorCommand,
    output logic [15:0]                 motorCommandB,
    output logic                        stepOut,
    output logic                        dirOut,
    output logic                        limitTrap
);
    import alae_pkg::*;

    logic        fwdSync;
    logic        revSync;
    logic        fwdPrev;
    logic        revPrev;
    alae_state_t state;
    alae_state_t next_state;
    logic        dirReverse;
    logic [15:0] speed;
    logic [15:0] peakCount;

    // RULE_17: synchronise limits
    alae_sync uFwdSync (
        .clock (clock),
        .rstn  (rstn),
        .din   (forwardLimitInput),
        .dout  (fwdSync)
    );
    alae_sync uRevSync (
        .clock (clock),
        .rstn  (rstn),
        .din   (reverseLimitInput),
        .dout  (revSync)
    );

    // Edge and blocking decode
    // Edges use the synchronised levels only, never the raw pins
    wire fwdRise    = fwdSync & ~fwdPrev;
    wire revRise    = revSync & ~revPrev;
    wire limitRise  = fwdRise | revRise;
    // RULE_01: forward block
    wire fwdBlocked = fwdSync & ~dirReverse;
    // RULE_02: reverse block
    wire revBlocked = revSync & dirReverse;
    wire hitLimit   = fwdBlocked | revBlocked;
    // RULE_07: refuse toward active limit
    wire beginBlock = beginDirReverse ? revSync : fwdSync;
    wire beginOk    = beginMotion & status.servoOn & ~beginBlock;
    wire beginRefused = beginMotion & beginBlock;
    wire [15:0] speedDec = (speed > cfg.limitDecelRate) ?
                           (speed - cfg.limitDecelRate) : ZERO_CMD;
    wire        peakWindow = (peakCount < PEAK_CYCLES);

    // Next state of the axis
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (beginOk) begin
                    next_state = ST_MOVE;
                end
            end
            ST_MOVE: begin
                // RULE_05: off on error
                if (limitRise && cfg.offOnError) begin
                    next_state = ST_OFF;
                // RULE_03: decelerate on limit
                end else if (hitLimit) begin
                    next_state = ST_DECEL;
                end
            end
            ST_DECEL: begin
                // RULE_04: hold position servo-on
                if (speedDec == ZERO_CMD) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        // RULE_11: motor off wins
        if (motorOffCommand) begin
            next_state = ST_OFF;
        end else if (state == ST_OFF && servoHereCommand) begin
            next_state = ST_IDLE;
        end else if (state != ST_OFF && limitRise && cfg.offOnError) begin
            next_state = ST_OFF;
        end
    end

    // Clamp demand; continuous limit normally, peak limit for short bursts
    wire [15:0] demandSel  = (state == ST_DECEL) ? speed : demandCommand;
    wire        demandNeg  = demandSel[15];
    wire [15:0] demandMag  = demandNeg ? (16'(~demandSel + 16'h0001)) : demandSel;
    // RULE_13: continuous clamp, never above the peak limit
    wire [15:0] contLim    = (cfg.continuousLimit > cfg.peakLimit) ? cfg.peakLimit :
                             cfg.continuousLimit;
    // RULE_14: peak clamp
    wire [15:0] activeLim  = peakWindow ? cfg.peakLimit : contLim;
    wire [15:0] fullLim    = (activeLim > CMD_FULL_POS) ? CMD_FULL_POS : activeLim;
    wire [15:0] clampMag   = (demandMag > fullLim) ? fullLim : demandMag;
    // RULE_15: signed full scale
    wire [15:0] clampCmd   = demandNeg ? (16'(~clampMag + 16'h0001)) : clampMag;
    wire        driving    = (state == ST_MOVE) || (state == ST_DECEL);
    wire        servoAxis  = (cfg.motorType == MT_SERVO);

    // State, direction and speed registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state      <= ST_OFF;
            fwdPrev    <= 1'b0;
            revPrev    <= 1'b0;
            dirReverse <= 1'b0;
            speed      <= ZERO_CMD;
        end else begin
            state   <= next_state;
            fwdPrev <= fwdSync;
            revPrev <= revSync;
            if (beginOk && state == ST_IDLE) begin
                dirReverse <= beginDirReverse;
            end
            if (next_state == ST_DECEL) begin
                speed <= (state == ST_MOVE) ? demandMag : speedDec;
            end else begin
                speed <= ZERO_CMD;
            end
        end
    end

    // Peak burst timer: restarts when demand falls within continuous limit
    always_ff @(posedge clock) begin
        if (!rstn) begin
            peakCount <= ZERO_CMD;
        end else if (demandMag <= cfg.continuousLimit) begin
            peakCount <= ZERO_CMD;
        end else if (peakWindow) begin
            peakCount <= peakCount + 16'h0001;
        end
    end

    // Status, trap and error registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            status    <= '0;
            limitTrap <= 1'b0;
        end else begin
            // RULE_09: flags follow inputs
            status.forwardLimitFlag <= fwdSync;
            status.reverseLimitFlag <= revSync;
            status.moving           <= (next_state == ST_MOVE) || (next_state == ST_DECEL);
            status.servoOn          <= (next_state != ST_OFF);
            // RULE_06: trap to handler
            limitTrap <= limitRise & cfg.handlerPresent;
            // RULE_08: error code 22
            if (beginRefused) begin
                status.errorCode <= ERR_LIMIT;
            end else if (errorClear) begin
                status.errorCode <= ERR_NONE;
            end
        end
    end

    // Amplifier and command output registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ampEnable     <= 1'b0;
            motorCommand  <= ZERO_CMD;
            motorCommandB <= ZERO_CMD;
            stepOut       <= 1'b0;
            dirOut        <= 1'b0;
        end else begin
            // RULE_10: active high enable
            ampEnable <= (next_state != ST_OFF);
            // RULE_12: motor type select
            motorCommand <= (servoAxis && driving && !hitLimit) ? clampCmd :
                            (servoAxis && state == ST_DECEL) ? clampCmd : ZERO_CMD;
            // RULE_16: second phase line
            motorCommandB <= (servoAxis && sineCommutation && driving) ?
                             demandPhaseB : ZERO_CMD;
            stepOut <= (!servoAxis) && driving && !hitLimit && stepPulseIn;
            dirOut  <= (!servoAxis) && dirReverse;
        end
    end
endmodule

//--- alae_axis_sva.sv
// Assertion checker for the axis limit and amplifier enable block
`timescale 1ns/1ps
module alae_axis_sva
    import alae_pkg::*;
(
    input wire logic                clock,
    input wire logic                rstn,
    input wire logic                forwardLimitInput,
    input wire logic                reverseLimitInput,
    input wire alae_pkg::alae_cfg_t cfg,
    input wire logic                beginMotion,
    input wire logic                beginDirReverse,
    input wire logic                motorOffCommand,
    input wire logic                servoHereCommand,
    input wire alae_pkg::alae_status_t status,
    input wire logic                ampEnable,
    input wire logic [15:0]         motorCommand,
    input wire logic                stepOut,
    input wire logic                dirOut,
    input wire logic                limitTrap
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // Begin toward an active forward limit from rest
    sequence refuseFwd;
        beginMotion && !beginDirReverse && status.servoOn && !status.moving
            && status.forwardLimitFlag && $past(forwardLimitInput, 2) && $past(rstn, 2);
    endsequence
    // Limit reached while moving, axis kept on
    sequence hitMove;
        $rose(status.forwardLimitFlag) && status.moving && !cfg.offOnError
            && cfg.limitDecelRate >= 16'h0100;
    endsequence
    AST_FLAG_FWD: assert property ($past(rstn, 3) |->
        status.forwardLimitFlag == $past(forwardLimitInput, 3)) else $error("fwd flag lag");
    AST_FLAG_REV: assert property ($past(rstn, 3) |->
        status.reverseLimitFlag == $past(reverseLimitInput, 3)) else $error("rev flag lag");
    AST_AMP_OFF: assert property (motorOffCommand |=>
        !ampEnable && !status.servoOn) else $error("amp not off");
    AST_AMP_ON: assert property (servoHereCommand && !motorOffCommand |=>
        ampEnable) else $error("amp not on");
    AST_ERR_FWD: assert property (refuseFwd |=>
        status.errorCode == ERR_LIMIT && !status.moving) else $error("begin not refused");
    AST_TRAP: assert property (limitTrap |-> cfg.handlerPresent
        ##1 !limitTrap) else $error("bad trap");
    AST_TRAP_RISE: assert property ($rose(status.forwardLimitFlag)
        && $past(cfg.handlerPresent) |-> limitTrap) else $error("no trap on limit");
    AST_OOE: assert property (cfg.offOnError && $rose(status.forwardLimitFlag) |->
        !ampEnable) else $error("axis not disabled");
    AST_SERVO_STEP: assert property ((cfg.motorType == MT_SERVO) [*2] |->
        !stepOut && !dirOut) else $error("step in servo mode");
    AST_PEAK: assert property ($stable(cfg.peakLimit) && !motorCommand[15] |->
        motorCommand <= cfg.peakLimit) else $error("peak exceeded");
    AST_DECEL: assert property (hitMove |->
        (ampEnable && status.servoOn) throughout (##[1:200] !status.moving))
        else $error("no decel stop");
endmodule

bind alae_axis alae_axis_sva i_sva (.clock, .rstn, .forwardLimitInput, .reverseLimitInput,
    .cfg, .beginMotion, .beginDirReverse, .motorOffCommand, .servoHereCommand, .status,
    .ampEnable, .motorCommand, .stepOut, .dirOut, .limitTrap);

//--- alae_partner.sv
// Model of the limit switches and the external amplifier of one axis
`timescale 1ns/1ps
module alae_partner (
    input  wire logic clock,
    input  wire logic fwdHit,
    input  wire logic revHit,
    input  wire logic ampEnable,
    output logic      forwardLimitInput,
    output logic      reverseLimitInput,
    output logic      ampOn
);
    // Switches follow the carriage just after an edge; amplifier follows its enable
    always @(posedge clock) begin
        forwardLimitInput <= #1 fwdHit;
        reverseLimitInput <= #1 revHit;
        ampOn             <= #1 ampEnable;
    end
endmodule

//--- alae_axis_tb.sv
// Self-checking testbench for the axis limit and amplifier enable block
`timescale 1ns/1ps
module alae_axis_tb;
    import alae_pkg::*;
    logic         clock = 1'h0;
    logic         rstn = 1'h0;
    logic         fwdHit = 1'h0, revHit = 1'h0, dirRev = 1'h0, sineOn = 1'h0;
    logic         stepIn = 1'h0, smp = 1'h0, fwdLim, revLim, stepLast = 1'h0;
    logic         ampEnable, stepOut, dirOut, limitTrap;
    logic [3:0]   cmdv = 4'h0;
    logic [15:0]  demand = 16'h0000, phaseB = 16'h0000, motorCommand;
    logic [28:0]  notes[$];
    logic [28:0]  note;
    logic [31:0]  seed = 32'h4A3D0770;
    alae_cfg_t    cfg = '{MT_SERVO, 1'h0, 1'h1, 16'h4000, 16'h6000, 16'h0100};
    alae_status_t status;
    int           errTotal = 0, compares = 0, cycles = 0, traps = 0;
    wire [28:0]   obs = {ampEnable, status, motorCommand};

    alae_partner i_partner (.clock, .fwdHit, .revHit, .ampEnable,
        .forwardLimitInput(fwdLim), .reverseLimitInput(revLim), .ampOn());
    alae_axis i_dut (.clock, .rstn, .forwardLimitInput(fwdLim), .reverseLimitInput(revLim),
        .cfg, .beginMotion(cmdv[0]), .beginDirReverse(dirRev), .motorOffCommand(cmdv[1]),
        .servoHereCommand(cmdv[2]), .sineCommutation(sineOn), .errorClear(cmdv[3]),
        .demandCommand(demand), .demandPhaseB(phaseB), .stepPulseIn(stepIn), .status,
        .ampEnable, .motorCommand, .motorCommandB(), .stepOut, .dirOut, .limitTrap);

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task completeRun;
        $display("compares %0d mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Command pulse: bit 0 begin, 1 motor off, 2 servo here, 3 error clear
    task pulse(input logic [3:0] p);
        cmdv <= p;
        cyc(1);
        cmdv <= 4'h0;
    endtask
    // Command outputs follow the registered state one edge later, so wait one edge
    task chk(input logic [28:0] e);
        notes.push_back(e);
        cyc(1);
        smp <= 1'h1;
        cyc(1);
        smp <= 1'h0;
        cyc(1);
    endtask

    always #5 clock = ~clock;
    // Random side inputs and hang guard
    always @(posedge clock) begin
        seed = xs(seed);
        stepLast = stepIn;
        stepIn <= seed[0];
        if (limitTrap === 1'h1)
            traps++;
        sineOn <= seed[5];
        phaseB <= seed[31:16];
        cycles++;
        if (cycles == 3000) begin
            errTotal++;
            completeRun();
        end
    end
    // Oldest note against settled outputs
    always @(negedge clock) begin
        if (smp) begin
            note = notes.pop_front();
            compares++;
            if (obs !== note)
                $display("mismatch t=%0t exp=%h got=%h", $time, note, obs);
            if (obs !== note)
                errTotal++;
        end
    end

    initial begin
        cyc(6);
        rstn <= 1'h1;
        cyc(1);
        chk({1'h0, 4'h0, ERR_NONE, ZERO_CMD});
        pulse(4'h4);
        chk({1'h1, 4'h1, ERR_NONE, ZERO_CMD});
        demand <= {2'h0, phaseB[13:0]};
        pulse(4'h1);
        chk({1'h1, 4'h3, ERR_NONE, demand});
        fwdHit <= 1'h1;
        cyc(100);
        chk({1'h1, 4'h9, ERR_NONE, ZERO_CMD});
        pulse(4'h1);
        chk({1'h1, 4'h9, ERR_LIMIT, ZERO_CMD});
        fwdHit <= 1'h0;
        cyc(4);
        pulse(4'h8);
        chk({1'h1, 4'h1, ERR_NONE, ZERO_CMD});
        pulse(4'h1);
        chk({1'h1, 4'h3, ERR_NONE, demand});
        pulse(4'h2);
        chk({1'h0, 4'h0, ERR_NONE, ZERO_CMD});
        pulse(4'h4);
        revHit <= 1'h1;
        dirRev <= 1'h1;
        cyc(5);
        pulse(4'h1);
        chk({1'h1, 4'h5, ERR_LIMIT, ZERO_CMD});
        revHit <= 1'h0;
        dirRev <= 1'h0;
        cfg.offOnError <= 1'h1;
        demand <= 16'h7000;
        pulse(4'h8);
        cyc(4);
        pulse(4'h1);
        chk({1'h1, 4'h3, ERR_NONE, 16'h6000});
        fwdHit <= 1'h1;
        cyc(8);
        chk({1'h0, 4'h8, ERR_NONE, ZERO_CMD});
        fwdHit <= 1'h0;
        cfg.motorType <= MT_STEP;
        pulse(4'h4);
        cyc(4);
        pulse(4'h1);
        chk({1'h1, 4'h3, ERR_NONE, ZERO_CMD});
        // Step output follows the step input while moving forward in step mode
        repeat (4) begin
            @(negedge clock);
            compares++;
            if ({stepOut, dirOut} !== {stepLast, 1'h0}) begin
                $display("mismatch t=%0t exp=%h got=%h", $time, {stepLast, 1'h0},
                         {stepOut, dirOut});
                errTotal++;
            end
        end
        // Two forward and one reverse activation, handler present
        compares++;
        if (traps !== 3) begin
            $display("mismatch t=%0t exp=%h got=%h", $time, 3, traps);
            errTotal++;
        end
        completeRun();
    end
endmodule
